// ==== mrr_result_bank.sv ====
// Result register bank with energy counters, impulse dividers and frequency meter
`timescale 1ns/100ps
module mrr_result_bank #(
  parameter int          TICK_CYCLES      = mrr_pkg::TICK_CYCLES,
  parameter logic [39:0] ACTIVE_QUANTUM   = mrr_pkg::ACTIVE_QUANTUM,
  parameter logic [39:0] REACTIVE_QUANTUM = mrr_pkg::REACTIVE_QUANTUM
) (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire logic [2:0]          operatingMode,
  input  wire logic [7:0]          displayRateTrim,
  input  wire logic                windowDone,
  input  wire mrr_pkg::mrr_window_t windowResults,
  input  wire logic [2:0]          lineZeroCross,
  input  wire logic [4:0]          regIndex,
  output logic      [31:0]         regData,
  output logic                     resultsFresh,
  output logic      [3:0]          meterPulse,
  output logic      [3:0]          displayPulse,
  output logic      [1:0]          lockedPhase
);
  mrr_pkg::mrr_window_t   results_q;
  logic [2:0][15:0]       pf_q;
  logic [3:0][31:0]       energy_q;
  logic [3:0][39:0]       energyAcc_q;
  logic [31:0]            elapsed_q;
  logic [15:0]            linePeriod_q;
  logic                   multiChannel;
  logic [3:0][39:0]       addAmt;
  logic [39:0]            quantum [4];
  logic signed [33:0]     activeSum;
  logic signed [33:0]     reactiveSum;

  assign multiChannel = (operatingMode == mrr_pkg::MODE_MULTI_EE) ||
                        (operatingMode == mrr_pkg::MODE_MULTI_UP);

  // Result latch, one refresh per ten-cycle window
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      results_q <= '0;
    end else if (windowDone) begin
      results_q <= windowResults;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      resultsFresh <= 1'b0;
    end else begin
      resultsFresh <= windowDone;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      elapsed_q <= '0;
    end else if (windowDone) begin
      elapsed_q <= elapsed_q + 32'h00000001;
    end
  end

  // Power factor: serial divide of |P| by |S|, one phase at a time
  // A window landing mid-divide does not restart it; phases not yet loaded divide its results
  mrr_pkg::mrr_pf_state_t pfState_q;
  logic [1:0]             pfPhase_q;
  logic [5:0]             pfStep_q;
  logic [31:0]            pfQuot_q;
  logic [16:0]            pfRem_q;
  logic [15:0]            pfDivisor_q;
  logic                   pfNegative_q;
  logic [16:0]            pfTrial;
  logic [31:0]            absActive;
  logic [15:0]            pfMag;

  always_comb begin
    absActive = results_q.activePower[pfPhase_q][31] ?
                32'(-results_q.activePower[pfPhase_q]) : results_q.activePower[pfPhase_q];
    pfTrial   = {pfRem_q[15:0], pfQuot_q[31]};
    // Quotient of one full-scale unit is about 2^16; halve and saturate
    pfMag     = (pfQuot_q[31:16] != 16'h0000 || pfQuot_q[15:1] == 15'h7fff) ?
                mrr_pkg::PF_PLUS_ONE : {1'b0, pfQuot_q[15:1]};
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pfState_q    <= mrr_pkg::PF_IDLE;
      pfPhase_q    <= 2'h0;
      pfStep_q     <= 6'h00;
      pfQuot_q     <= '0;
      pfRem_q      <= '0;
      pfDivisor_q  <= '0;
      pfNegative_q <= 1'b0;
      pf_q         <= '0;
    end else begin
      case (pfState_q)
        mrr_pkg::PF_IDLE: begin
          if (windowDone) begin
            pfPhase_q <= 2'h0;
            pfStep_q  <= 6'h3f;
            pfState_q <= mrr_pkg::PF_DIVIDE;
          end
        end
        mrr_pkg::PF_DIVIDE: begin
          if (pfStep_q == 6'h3f) begin
            pfQuot_q     <= absActive;
            pfRem_q      <= '0;
            pfDivisor_q  <= results_q.apparentPower[pfPhase_q];
            pfNegative_q <= results_q.reactivePower[pfPhase_q][31];
            pfStep_q     <= 6'h00;
          end else begin
            if (pfTrial >= {1'b0, pfDivisor_q}) begin
              pfRem_q  <= pfTrial - {1'b0, pfDivisor_q};
              pfQuot_q <= {pfQuot_q[30:0], 1'b1};
            end else begin
              pfRem_q  <= pfTrial;
              pfQuot_q <= {pfQuot_q[30:0], 1'b0};
            end
            if (pfStep_q == 6'h1f) begin
              pfState_q <= mrr_pkg::PF_STORE;
            end
            pfStep_q <= pfStep_q + 6'h01;
          end
        end
        mrr_pkg::PF_STORE: begin
          // Zero apparent power has no ratio; report zero
          if (pfDivisor_q == 16'h0000) begin
            pf_q[pfPhase_q] <= '0;
          end else if (pfNegative_q) begin
            pf_q[pfPhase_q] <= 16'(-pfMag);
          end else begin
            pf_q[pfPhase_q] <= pfMag;
          end
          if (pfPhase_q == 2'h2) begin
            pfState_q <= mrr_pkg::PF_IDLE;
          end else begin
            pfPhase_q <= pfPhase_q + 2'h1;
            pfStep_q  <= 6'h3f;
            pfState_q <= mrr_pkg::PF_DIVIDE;
          end
        end
        default: pfState_q <= mrr_pkg::PF_IDLE;
      endcase
    end
  end

  // Energy: window power sums, or per-phase powers in multi-channel, feed remainder accumulators
  always_comb begin
    // Sign-extend each phase so export and import cancel
    activeSum   = 34'(signed'(windowResults.activePower[0])) +
                  34'(signed'(windowResults.activePower[1])) +
                  34'(signed'(windowResults.activePower[2]));
    reactiveSum = 34'(signed'(windowResults.reactivePower[0])) +
                  34'(signed'(windowResults.reactivePower[1])) +
                  34'(signed'(windowResults.reactivePower[2]));
    addAmt = '0;
    if (multiChannel) begin
      for (int k = 0; k < 3; k++) begin
        if (!windowResults.activePower[k][31]) begin
          addAmt[k] = 40'(windowResults.activePower[k]);
        end
      end
    end else begin
      if (activeSum[33]) begin
        addAmt[1] = 40'(-activeSum);
      end else begin
        addAmt[0] = 40'(activeSum);
      end
      if (reactiveSum[33]) begin
        addAmt[3] = 40'(-reactiveSum);
      end else begin
        addAmt[2] = 40'(reactiveSum);
      end
    end
    quantum[0] = ACTIVE_QUANTUM;
    quantum[1] = ACTIVE_QUANTUM;
    quantum[2] = multiChannel ? ACTIVE_QUANTUM : REACTIVE_QUANTUM;
    quantum[3] = REACTIVE_QUANTUM;
  end

  // At most one count per cycle; surplus drains over the following cycles
  logic [3:0] energyStep;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      energyStep[k] = energyAcc_q[k] >= quantum[k];
    end
    // Register fifteen stands still while phases run as separate meters
    energyStep[3] = energyStep[3] && !multiChannel;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      energyAcc_q <= '0;
      energy_q    <= '0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        energyAcc_q[k] <= energyAcc_q[k] - (energyStep[k] ? quantum[k] : 40'h0) +
                          (windowDone ? addAmt[k] : 40'h0);
        if (energyStep[k]) begin
          energy_q[k] <= energy_q[k] + 32'h00000001;
        end
      end
    end
  end

  // Impulse dividers, one pair per quantity
  logic [3:0][0:0] mcCount_q;
  logic [3:0][8:0] dispCount_q;
  logic [8:0]      dispDivisor;

  always_comb begin
    if (operatingMode == mrr_pkg::MODE_SEVEN) begin
      dispDivisor = mrr_pkg::DISP_LSBS_MODE7;
    end else begin
      dispDivisor = mrr_pkg::DISP_LSBS + {1'b0, displayRateTrim};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mcCount_q    <= '0;
      dispCount_q  <= '0;
      meterPulse   <= '0;
      displayPulse <= '0;
    end else begin
      for (int k = 0; k < 4; k++) begin
        meterPulse[k]   <= 1'b0;
        displayPulse[k] <= 1'b0;
        if (energyStep[k]) begin
          if ({8'h00, mcCount_q[k]} >= mrr_pkg::MC_LSBS - 9'h001) begin
            mcCount_q[k]  <= '0;
            meterPulse[k] <= 1'b1;
          end else begin
            mcCount_q[k] <= mcCount_q[k] + 1'b1;
          end
          // Compare with >= so a lowered trim never strands the count
          if (dispCount_q[k] + 9'h001 >= dispDivisor) begin
            dispCount_q[k]  <= '0;
            displayPulse[k] <= 1'b1;
          end else begin
            dispCount_q[k] <= dispCount_q[k] + 9'h001;
          end
        end
      end
    end
  end

  // Line period: 1.25ms ticks over 50 cycles of the locked phase
  logic [31:0] tickDiv_q;
  logic        tick;
  logic [5:0]  crossCount_q;
  logic        armed_q;
  logic [15:0] periodTicks_q;
  logic        lockLost;
  logic [1:0]  nextPhase;
  logic [15:0] periodNext;

  assign tick = (tickDiv_q == 32'(TICK_CYCLES - 1));

  // A tick on a crossing edge still belongs to the running period
  assign periodNext = (tick && periodTicks_q != mrr_pkg::LINE_PERIOD_MAX) ?
                      periodTicks_q + 16'h0001 : periodTicks_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n || tick) begin
      tickDiv_q <= '0;
    end else begin
      tickDiv_q <= tickDiv_q + 32'h00000001;
    end
  end

  always_comb begin
    lockLost  = windowDone &&
                (windowResults.rmsVoltage[lockedPhase] < mrr_pkg::VOLT_PRESENT_MIN);
    nextPhase = lockedPhase;
    for (int k = 2; k >= 0; k--) begin
      if (windowResults.rmsVoltage[k] >= mrr_pkg::VOLT_PRESENT_MIN && 2'(k) != lockedPhase) begin
        nextPhase = 2'(k);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      lockedPhase   <= 2'h0;
      armed_q       <= 1'b0;
      crossCount_q  <= '0;
      periodTicks_q <= '0;
      linePeriod_q  <= '0;
    end else if (lockLost) begin
      lockedPhase <= nextPhase;
      armed_q     <= 1'b0;
    end else if (lineZeroCross[lockedPhase]) begin
      if (!armed_q) begin
        armed_q       <= 1'b1;
        crossCount_q  <= '0;
        periodTicks_q <= '0;
      end else if (crossCount_q == mrr_pkg::LINE_CYCLES - 6'h01) begin
        linePeriod_q  <= periodNext;
        crossCount_q  <= '0;
        periodTicks_q <= '0;
      end else begin
        crossCount_q  <= crossCount_q + 6'h01;
        periodTicks_q <= periodNext;
      end
    end else if (armed_q) begin
      periodTicks_q <= periodNext;
    end
  end

  // Read port: registered word, narrow results zero-extended
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      regData <= '0;
    end else begin
      if (regIndex < mrr_pkg::REG_REACTIVE1) begin
        regData <= results_q.activePower[regIndex[1:0]];
      end else if (regIndex < mrr_pkg::REG_APPARENT1) begin
        regData <= results_q.reactivePower[2'(regIndex - mrr_pkg::REG_REACTIVE1)];
      end else if (regIndex < mrr_pkg::REG_PF1) begin
        regData <= {16'h0000, results_q.apparentPower[2'(regIndex - mrr_pkg::REG_APPARENT1)]};
      end else if (regIndex < mrr_pkg::REG_ENERGY0) begin
        regData <= {16'h0000, pf_q[2'(regIndex - mrr_pkg::REG_PF1)]};
      end else if (regIndex < mrr_pkg::REG_ELAPSED) begin
        regData <= energy_q[2'(regIndex - mrr_pkg::REG_ENERGY0)];
      end else if (regIndex == mrr_pkg::REG_ELAPSED) begin
        regData <= elapsed_q;
      end else if (regIndex == mrr_pkg::REG_LINE_PERIOD) begin
        regData <= {16'h0000, linePeriod_q};
      end else if (regIndex == mrr_pkg::REG_RESERVED) begin
        regData <= {16'h0000, mrr_pkg::RESERVED_VALUE};
      end else if (regIndex < mrr_pkg::REG_CURRENT1) begin
        regData <= {16'h0000, results_q.rmsVoltage[2'(regIndex - mrr_pkg::REG_VOLTAGE1)]};
      end else if (regIndex < 5'(mrr_pkg::NUM_REGS)) begin
        regData <= {16'h0000, results_q.lineCurrent[2'(regIndex - mrr_pkg::REG_CURRENT1)]};
      end else begin
        regData <= '0;
      end
    end
  end
endmodule

// ==== mrr_pkg.sv ====
// Constants, types and encodings of the metering result register bank
//Contract
//- Twenty-five result registers, 32 or 16 bits wide
//- Multi-channel: registers 12-14 per-phase export, 15 unused
//- Active power full scale reads 258fc2f7
//- Reactive power full scale reads plus/minus 2231594d
//- Apparent power full scale reads 258e
//- Power factor is |P|/|S| signed by Q
//- Power factor 7fff one, 8001 minus one
//- Frequency register counts 50 line cycles in 1.25ms
//- Frequency value is 40000 over hertz, max 7fff
//- Frequency locks to one phase, switches when lost
//- Voltage full scale 7a8b, current full scale 7da4
//- Four energy counters, one count per 0.4Wh
//- Counters sorted export, import, inductive, capacitive
//- Meter-constant impulse every 2 counter increments
//- Display impulse every 25 increments, modes 1-4
//- Display divisor is 25 plus rate trim
//- Mode seven needs 250 increments per display impulse
//- Elapsed ten-cycle window counter, 32 bits
//- Register eighteen reserved, no result
//- Energy, time and impulse scales follow the clock; only the tick is derived from it, energy quanta are fixed
//- Results refreshed once per ten-cycle window
package mrr_pkg;
  localparam int          NUM_REGS         = 25;
  localparam logic [4:0]  REG_ACTIVE1      = 5'h00;
  localparam logic [4:0]  REG_REACTIVE1    = 5'h03;
  localparam logic [4:0]  REG_APPARENT1    = 5'h06;
  localparam logic [4:0]  REG_PF1          = 5'h09;
  localparam logic [4:0]  REG_ENERGY0      = 5'h0c;
  localparam logic [4:0]  REG_ELAPSED      = 5'h10;
  localparam logic [4:0]  REG_LINE_PERIOD  = 5'h11;
  localparam logic [4:0]  REG_RESERVED     = 5'h12;
  localparam logic [4:0]  REG_VOLTAGE1     = 5'h13;
  localparam logic [4:0]  REG_CURRENT1     = 5'h16;
  localparam logic [15:0] PF_PLUS_ONE      = 16'h7fff;
  localparam logic [15:0] RESERVED_VALUE   = 16'h0000;
  localparam logic [15:0] LINE_PERIOD_MAX  = 16'h7fff;
  localparam logic [5:0]  LINE_CYCLES      = 6'h32;
  localparam int          CLK_PERIOD_PS    = 10000;
  localparam int          TICK_TIME_US     = 1250;
  localparam int          TICK_CYCLES      = TICK_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam logic [15:0] VOLT_FULL_SCALE  = 16'h7a8b;
  localparam logic [15:0] VOLT_PRESENT_MIN = VOLT_FULL_SCALE / 16'h000a;
  localparam logic [8:0]  MC_LSBS          = 9'h002;
  localparam logic [8:0]  DISP_LSBS        = 9'h019;
  localparam logic [8:0]  DISP_LSBS_MODE7  = 9'h0fa;
  localparam logic [2:0]  MODE_MULTI_EE    = 3'h2;
  localparam logic [2:0]  MODE_MULTI_UP    = 3'h4;
  localparam logic [2:0]  MODE_SEVEN       = 3'h7;
  // Power-register units per 0.4Wh with 0.2s windows at nominal clock
  localparam logic [39:0] ACTIVE_QUANTUM   = 40'h000c853dfd;
  localparam logic [39:0] REACTIVE_QUANTUM = 40'h000b65cfb8;

  typedef struct packed {
    logic signed [2:0][31:0] activePower;
    logic signed [2:0][31:0] reactivePower;
    logic        [2:0][15:0] apparentPower;
    logic        [2:0][15:0] rmsVoltage;
    logic        [2:0][15:0] lineCurrent;
  } mrr_window_t;

  typedef enum logic [1:0] {
    PF_IDLE,
    PF_DIVIDE,
    PF_STORE
  } mrr_pf_state_t;
endpackage

// ==== mrr_result_bank_monitor.sv ====
// Port-level assertions for the result register bank
`timescale 1ns/100ps
module mrr_result_bank_monitor (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        windowDone,
  input wire logic [4:0]  regIndex,
  input wire logic [31:0] regData,
  input wire logic        resultsFresh,
  input wire logic [3:0]  meterPulse,
  input wire logic [3:0]  displayPulse,
  input wire logic [1:0]  lockedPhase
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_fresh; ##1 resultsFresh; endsequence
  sequence s_quiet; ##1 !displayPulse[0] [*8]; endsequence
  property p_fresh; windowDone |-> s_fresh; endproperty
  property p_fresh_cause; resultsFresh |-> $past(windowDone); endproperty
  property p_rsvd; regIndex == mrr_pkg::REG_RESERVED |=> regData == 32'h00000000; endproperty
  property p_range; regIndex > 5'h18 |=> regData == 32'h00000000; endproperty
  property p_meter; meterPulse != 4'h0 |=> (meterPulse & $past(meterPulse)) == 4'h0; endproperty
  property p_disp; displayPulse[0] |-> s_quiet; endproperty
  property p_lock; lockedPhase != $past(lockedPhase) |-> $past(windowDone) && lockedPhase != 2'h3; endproperty
  property p_reset;
    !$past(rst_n) |-> regData == 32'h00000000 && meterPulse == 4'h0 && lockedPhase == 2'h0;
  endproperty
  a_fresh: assert property (p_fresh) else $error("results not flagged after window");
  a_fresh_cause: assert property (p_fresh_cause) else $error("fresh flag without window");
  a_rsvd: assert property (p_rsvd) else $error("reserved register not zero");
  a_range: assert property (p_range) else $error("unmapped index not zero");
  a_meter: assert property (p_meter) else $error("meter impulses back to back");
  a_disp: assert property (p_disp) else $error("display impulses too close");
  a_lock: assert property (p_lock) else $error("tracked phase moved off window");
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
endmodule

bind mrr_result_bank mrr_result_bank_monitor u_mon (.core_clk(core_clk), .rst_n(rst_n), .windowDone(windowDone),
  .regIndex(regIndex), .regData(regData), .resultsFresh(resultsFresh), .meterPulse(meterPulse),
  .displayPulse(displayPulse), .lockedPhase(lockedPhase));

// ==== mrr_pulse_counter.sv ====
// Impulse counters standing on the far side of the pulse outputs
`timescale 1ns/100ps
module mrr_pulse_counter (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [3:0]       meterPulse,
  input  wire logic [3:0]       displayPulse,
  output logic      [3:0][15:0] meterCount,
  output logic      [3:0][15:0] displayCount
);
  // One counter per quantity, like separate mechanical registers
  always_ff @(posedge core_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (!rst_n) meterCount[k] <= 16'h0000;
      else if (meterPulse[k]) meterCount[k] <= meterCount[k] + 16'h0001;
    end
  end
  always_ff @(posedge core_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (!rst_n) displayCount[k] <= 16'h0000;
      else if (displayPulse[k]) displayCount[k] <= displayCount[k] + 16'h0001;
    end
  end
endmodule

// ==== mrr_result_bank_test.sv ====
// Self-checking bench for the result register bank
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin nErrors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module mrr_result_bank_test;
  logic                 core_clk;
  logic                 rst_n;
  logic [2:0]           operatingMode;
  logic [7:0]           displayRateTrim;
  logic                 windowDone;
  mrr_pkg::mrr_window_t windowResults;
  logic [2:0]           lineZeroCross;
  logic [4:0]           regIndex;
  logic [31:0]          regData;
  logic                 resultsFresh;
  logic [3:0]           meterPulse;
  logic [3:0]           displayPulse;
  logic [1:0]           lockedPhase;
  logic [3:0][15:0]     meterCount;
  logic [3:0][15:0]     displayCount;
  mrr_pkg::mrr_window_t w;
  int                   nErrors;
  int                   testsRun;

  // Short counts keep the run brief
  mrr_result_bank #(.TICK_CYCLES(10), .ACTIVE_QUANTUM(40'h64), .REACTIVE_QUANTUM(40'h64)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .operatingMode(operatingMode), .displayRateTrim(displayRateTrim),
    .windowDone(windowDone), .windowResults(windowResults), .lineZeroCross(lineZeroCross),
    .regIndex(regIndex), .regData(regData), .resultsFresh(resultsFresh), .meterPulse(meterPulse),
    .displayPulse(displayPulse), .lockedPhase(lockedPhase));
  mrr_pulse_counter u_cnt (.core_clk(core_clk), .rst_n(rst_n), .meterPulse(meterPulse),
    .displayPulse(displayPulse), .meterCount(meterCount), .displayCount(displayCount));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input logic [4:0] idx, input logic [31:0] ex);
    @(posedge core_clk);
    #1 regIndex = idx;
    @(posedge core_clk);
    #1 `CHK($sformatf("reg%0d", idx), ex, regData)
  endtask

  task automatic win(input logic [2:0] md, input logic [7:0] trim, input int n);
    @(posedge core_clk);
    #1 operatingMode = md;
    displayRateTrim = trim;
    windowResults = w;
    windowDone = 1'b1;
    @(posedge core_clk);
    #1 windowDone = 1'b0;
    `CHK("fresh", 1'b1, resultsFresh)
    repeat (n) @(posedge core_clk);
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", testsRun, nErrors);
    if (nErrors == 0 && testsRun > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    #200000;
    nErrors++;
    results();
  end

  initial begin
    {rst_n, windowDone, lineZeroCross, regIndex, displayRateTrim} = '0;
    operatingMode = 3'h1;
    windowResults = '0;
    repeat (6) @(posedge core_clk);
    #1 rst_n = 1'b1;
    for (int k = 0; k < 25; k++) chk(k[4:0], 32'h0);
    for (int k = 18; k < 32; k++) if (k != 19) chk(k[4:0], 32'h0);
    $display("test reset_and_unmapped done");
    // Crossing every 40 cycles, ticks every 10: 50 periods give 200 ticks
    for (int k = 0; k < 51; k++) begin
      @(posedge core_clk);
      #1 lineZeroCross = 3'h7;
      @(posedge core_clk);
      #1 lineZeroCross = 3'h0;
      repeat (38) @(posedge core_clk);
    end
    chk(mrr_pkg::REG_LINE_PERIOD, 32'hc8);
    $display("test line_period done");
    w = '0;
    w.activePower[0] = 32'h000186a0;
    w.activePower[1] = 32'h000186a0;
    w.reactivePower[0] = 32'h00000032;
    w.reactivePower[1] = 32'hffffffce;
    w.apparentPower[0] = 16'h0001;
    w.apparentPower[1] = 16'h0001;
    w.rmsVoltage = {3{16'h7a8b}};
    w.lineCurrent = {3{16'h7da4}};
    win(3'h1, 8'h00, 2100);
    chk(5'h00, 32'h000186a0);
    chk(5'h04, 32'hffffffce);
    chk(5'h06, 32'h1);
    chk(5'h09, 32'h7fff);
    chk(5'h0a, 32'h8001);
    chk(5'h0b, 32'h0);
    chk(5'h0c, 32'h7d0);
    chk(5'h13, 32'h7a8b);
    chk(5'h18, 32'h7da4);
    `CHK("display0", 16'd80, displayCount[0])
    $display("test export_window done");
    w = '0;
    w.activePower[0] = 32'hffff8ad0;
    w.reactivePower[0] = 32'hffffd8f0;
    w.rmsVoltage = {3{16'h7a8b}};
    win(3'h1, 8'h05, 500);
    chk(5'h0d, 32'h12c);
    chk(5'h0f, 32'h64);
    `CHK("display1", 16'd10, displayCount[1])
    $display("test import_trim done");
    w.activePower[0] = 32'h0;
    w.reactivePower[0] = 32'h0000c350;
    w.activePower[2:1] = {32'h00800000, 32'hff800000};
    w.reactivePower[2:1] = {32'h00000001, 32'hffffffff};
    w.apparentPower[2:1] = {2{16'h0100}};
    win(3'h7, 8'h05, 700);
    chk(5'h0e, 32'h1f4);
    chk(5'h0a, 32'hc000);
    chk(5'h0b, 32'h4000);
    `CHK("display2", 16'd2, displayCount[2])
    $display("test mode_seven done");
    w = '0;
    w.activePower = {32'hfffffe0c, 32'h000007d0, 32'h000003e8};
    w.rmsVoltage = {16'h7a8b, 16'h7a8b, 16'h0000};
    win(3'h2, 8'h05, 300);
    chk(5'h0c, 32'h7da);
    chk(5'h0d, 32'h140);
    chk(5'h0e, 32'h1f4);
    chk(5'h0f, 32'h64);
    chk(mrr_pkg::REG_ELAPSED, 32'h4);
    `CHK("locked", 2'h1, lockedPhase)
    `CHK("meter", {16'd50, 16'd250, 16'd160, 16'd1005}, meterCount)
    `CHK("display", {16'd3, 16'd2, 16'd10, 16'd80}, displayCount)
    $display("test multi_channel done");
    @(posedge core_clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 rst_n = 1'b1;
    chk(mrr_pkg::REG_ELAPSED, 32'h0);
    chk(5'h0c, 32'h0);
    `CHK("relock", 2'h0, lockedPhase)
    $display("test mid_reset done");
    results();
  end
endmodule
